// File: core/dpm_defs.svh
`ifndef DPM_DEFS_SVH
`define DPM_DEFS_SVH

// Register port byte offsets.
`define DPM_MAP_BASE   12'h800
`define DPM_MAP_LAST   12'hBFC
`define DPM_OFF_VIEW   12'h010
`define DPM_OFF_CAR    12'h014

// Field positions of a map entry word.
`define DPM_VALID_BIT  31
`define DPM_PFN_MSB    20
`define DPM_ZERO_MSB   30
`define DPM_ZERO_LSB   21

// Virtual address bits that select a map entry.
`define DPM_IDX_MSB    16
`define DPM_IDX_LSB    9
`define DPM_VA_W       17

// Step of the virtual address per sequencer advance, in bytes.
`define DPM_ADDR_STEP  17'h00004

// Reset images.
`define DPM_WORD_RST   32'h00000000
`define DPM_VA_RST     17'h00000
`define DPM_CMD_RST    4'h0

`endif

// File: core/dpm_map_ram.sv
`timescale 1ns/1ns
`default_nettype none
module dpm_map_ram #(
   parameter int ENTRIES = 256,
   parameter int IDX_W   = 8
) (
   input  wire logic               sys_clk,
   input  wire logic               rst,
   input  wire logic               wr_en,
   input  wire logic [IDX_W-1:0]   wr_idx,
   input  wire dpm_pkg::dpm_entry_s wr_data,
   input  wire logic [IDX_W-1:0]   rd_a_idx,
   output dpm_pkg::dpm_entry_s     rd_a_data,
   input  wire logic [IDX_W-1:0]   rd_b_idx,
   output dpm_pkg::dpm_entry_s     rd_b_data
);

   // Index width must cover the table exactly.
   if (ENTRIES != (1 << IDX_W)) begin : g_bad_size
      $error("dpm_map_ram: ENTRIES must equal 2**IDX_W");
   end

   dpm_pkg::dpm_entry_s mem [ENTRIES];

   // Reset clears every entry so that no stale frame looks valid.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         for (int i = 0; i < ENTRIES; i++) begin
            mem[i] <= '0;
         end
      end else if (wr_en) begin
         mem[wr_idx] <= wr_data;
      end
   end

   // Two independent read ports: host side and translation side.
   assign rd_a_data = mem[rd_a_idx];
   assign rd_b_data = mem[rd_b_idx];

endmodule
`default_nettype wire

// File: core/dpm_page_map.sv
// Operation
// RULE1 - Selected view is read-only, entry layout.
// RULE2 - View shows entry at address bits 16-9.
// RULE3 - Capture register is read-only, valid when busy.
// RULE4 - Capture holds full 32-bit command/address word.
// RULE5 - 256 independently addressable map entries.
// RULE6 - Host writes map only when idle.
// RULE7 - Busy map write dropped, page error set.
// RULE8 - Rejected write interrupts at transfer end.
// RULE9 - Valid bit 31, zeros 30-21, frame 20-0.
// RULE10 - Invalid entry aborts transfer, flags error.
`timescale 1ns/1ns
`default_nettype none
`include "dpm_defs.svh"
module dpm_page_map #(
   parameter int MAP_ENTRIES = 256
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic [11:0]      reg_addr,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   input  wire logic [31:0]      reg_wdata,
   output logic [31:0]           reg_rdata,
   output logic                  reg_rvalid,
   input  wire dpm_pkg::dpm_seq_s seq,
   input  wire logic             interrupt_enable_control,
   input  wire logic             page_error_clr,
   input  wire logic             invalid_err_clr,
   output logic                  transfer_active_flag,
   output logic                  page_error_flag,
   output logic                  map_invalid_flag,
   output logic                  xfer_abort,
   output logic                  cpu_irq,
   output logic [31:0]           phys_cmd_addr
);

   localparam int IDX_W = 8;

   // The index field of the virtual address is fixed at eight bits.
   if (MAP_ENTRIES != 256) begin : g_bad_entries
      $error("dpm_page_map: MAP_ENTRIES must be 256");
   end

   // Packs a stored entry into its register image.
   function automatic logic [31:0] entry_word(input dpm_pkg::dpm_entry_s e);
      entry_word = {e.valid, 10'h000, e.pfn}; // RULE9
   endfunction

   dpm_pkg::dpm_state_e state_r;
   dpm_pkg::dpm_state_e state_nxt;
   logic                busy_r;
   logic [16:0]         va_r;
   logic [16:0]         va_nxt;
   logic [3:0]          cmd_r;
   logic [31:0]         view_r;
   logic [31:0]         car_r;
   logic                pend_r;
   logic                pge_r;
   logic                inv_r;
   logic                abort_r;
   logic                irq_r;
   logic [31:0]         rdata_r;
   logic                rvalid_r;

   dpm_pkg::dpm_entry_s host_entry;
   dpm_pkg::dpm_entry_s sel_entry;
   dpm_pkg::dpm_entry_s wr_entry;

   // Register port decode.
   wire              map_hit   = reg_addr >= `DPM_MAP_BASE && reg_addr <= `DPM_MAP_LAST
                                 && reg_addr[1:0] == 2'h0;
   wire              view_hit  = reg_addr == `DPM_OFF_VIEW;
   wire              car_hit   = reg_addr == `DPM_OFF_CAR;
   wire [IDX_W-1:0]  host_idx  = reg_addr[9:2]; // RULE5
   wire              map_wr    = reg_wr && map_hit;
   wire              map_wr_ok = map_wr && !busy_r; // RULE6
   wire              reject    = map_wr && busy_r; // RULE7

   // Translation side: the entry under the current virtual page.
   wire [IDX_W-1:0]  sel_idx     = va_r[`DPM_IDX_MSB:`DPM_IDX_LSB]; // RULE2
   wire              invalid_hit = busy_r && !sel_entry.valid; // RULE10
   wire              xfer_end    = busy_r && (seq.done || invalid_hit);

   // Only the stored fields are kept; bits 30-21 are never stored.
   assign wr_entry.valid = reg_wdata[`DPM_VALID_BIT];
   assign wr_entry.pfn   = reg_wdata[`DPM_PFN_MSB:0];

   dpm_map_ram #(
      .ENTRIES (MAP_ENTRIES),
      .IDX_W   (IDX_W)
   ) u_ram (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .wr_en     (map_wr_ok),
      .wr_idx    (host_idx),
      .wr_data   (wr_entry),
      .rd_a_idx  (host_idx),
      .rd_a_data (host_entry),
      .rd_b_idx  (sel_idx),
      .rd_b_data (sel_entry)
   );

   // Transfer state: start only from idle, end on done or on a bad entry.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         dpm_pkg::DPM_IDLE: begin
            if (seq.start) begin
               state_nxt = dpm_pkg::DPM_ACTIVE;
            end
         end
         dpm_pkg::DPM_ACTIVE: begin
            if (xfer_end) begin
               state_nxt = dpm_pkg::DPM_IDLE; // RULE10
            end
         end
         default: state_nxt = dpm_pkg::DPM_IDLE;
      endcase
   end

   // Virtual address is loaded at start and stepped by the sequencer.
   assign va_nxt = (state_r == dpm_pkg::DPM_IDLE && seq.start) ? seq.va :
                   (busy_r && seq.advance) ? va_r + `DPM_ADDR_STEP : va_r;

   // Read data selection; unmapped offsets return zero.
   wire [31:0] rdata_nxt = map_hit  ? entry_word(host_entry) : // RULE9
                           view_hit ? view_r :
                           car_hit  ? car_r : `DPM_WORD_RST;

   // Command/address word: command nibble over a longword address.
   wire [31:0] car_nxt = {cmd_r, sel_entry.pfn, va_r[8:2]}; // RULE4

   // Sticky flags: a new event wins over a clear in the same cycle.
   wire pge_nxt  = reject || (pge_r && !page_error_clr); // RULE7
   wire inv_nxt  = invalid_hit || (inv_r && !invalid_err_clr); // RULE10
   wire pend_nxt = (reject || pend_r) && !xfer_end;
   wire irq_nxt  = xfer_end && (pend_r || reject) && interrupt_enable_control; // RULE8

   // State and address registers.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_r <= dpm_pkg::DPM_IDLE;
         busy_r  <= 1'b0;
         va_r    <= `DPM_VA_RST;
         cmd_r   <= `DPM_CMD_RST;
      end else begin
         state_r <= state_nxt;
         busy_r  <= state_nxt == dpm_pkg::DPM_ACTIVE;
         va_r    <= va_nxt;
         cmd_r   <= (state_r == dpm_pkg::DPM_IDLE && seq.start) ? seq.cmd : cmd_r;
      end
   end

   // Views follow the live entry only while busy and hold otherwise, so
   // software sees the last transfer's image after it ends.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         view_r <= `DPM_WORD_RST;
         car_r  <= `DPM_WORD_RST;
      end else if (busy_r) begin
         view_r <= entry_word(sel_entry); // RULE1
         car_r  <= car_nxt; // RULE3
      end
   end

   // Flags, events and read data.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pge_r    <= 1'b0;
         inv_r    <= 1'b0;
         pend_r   <= 1'b0;
         abort_r  <= 1'b0;
         irq_r    <= 1'b0;
         rdata_r  <= `DPM_WORD_RST;
         rvalid_r <= 1'b0;
      end else begin
         pge_r    <= pge_nxt;
         inv_r    <= inv_nxt;
         pend_r   <= pend_nxt;
         abort_r  <= invalid_hit;
         irq_r    <= irq_nxt;
         rdata_r  <= reg_rd ? rdata_nxt : rdata_r;
         rvalid_r <= reg_rd;
      end
   end

   // Writes to the view and capture offsets have no effect at all.
   assign reg_rdata            = rdata_r;
   assign reg_rvalid           = rvalid_r;
   assign transfer_active_flag = busy_r;
   assign page_error_flag      = pge_r;
   assign map_invalid_flag     = inv_r;
   assign xfer_abort           = abort_r;
   assign cpu_irq              = irq_r;
   assign phys_cmd_addr        = car_r;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   property p_view_read;
      reg_rd && view_hit |=> reg_rvalid && reg_rdata == $past(view_r);
   endproperty
   a_view_read: assert property (p_view_read) else $error("view read wrong"); // RULE1

   property p_view_index;
      busy_r |=> view_r[20:0] == $past(sel_entry.pfn) && view_r[31] == $past(sel_entry.valid);
   endproperty
   a_view_index: assert property (p_view_index) else $error("view not selected entry"); // RULE2

   property p_car_hold;
      !busy_r |=> $stable(car_r) && $stable(view_r);
   endproperty
   a_car_hold: assert property (p_car_hold) else $error("capture changed while idle"); // RULE3

   property p_car_word;
      busy_r |=> car_r == {$past(cmd_r), $past(sel_entry.pfn), $past(va_r[8:2])};
   endproperty
   a_car_word: assert property (p_car_word) else $error("capture word wrong"); // RULE4

   property p_map_rw;
      (map_wr && !busy_r) ##1 (reg_rd && !reg_wr && reg_addr == $past(reg_addr))
      |=> reg_rdata[20:0] == $past(reg_wdata[20:0], 2);
   endproperty
   a_map_rw: assert property (p_map_rw) else $error("map entry readback wrong"); // RULE5

   property p_reject;
      map_wr && busy_r |=> page_error_flag && (pend_r || $past(xfer_end));
   endproperty
   a_reject: assert property (p_reject) else $error("busy map write not flagged"); // RULE7

   property p_irq_end;
      xfer_end && (pend_r || reject) && interrupt_enable_control |=> cpu_irq ##1 !cpu_irq;
   endproperty
   a_irq_end: assert property (p_irq_end) else $error("end interrupt missing"); // RULE8

   property p_irq_gate;
      !interrupt_enable_control |=> !cpu_irq;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("interrupt while disabled"); // RULE8

   property p_zero_bits;
      reg_rvalid && $past(map_hit || view_hit) |-> reg_rdata[30:21] == 10'h000;
   endproperty
   a_zero_bits: assert property (p_zero_bits) else $error("unused bits not zero"); // RULE9

   property p_invalid;
      invalid_hit |=> xfer_abort && map_invalid_flag && !transfer_active_flag;
   endproperty
   a_invalid: assert property (p_invalid) else $error("invalid entry not caught"); // RULE10

endmodule
`default_nettype wire

// File: core/dpm_pkg.sv
package dpm_pkg;

   // One map entry as stored.
   typedef struct packed {
      logic        valid;
      logic [20:0] pfn;
   } dpm_entry_s;

   // Requests from the data-transfer sequencer.
   typedef struct packed {
      logic        start;
      logic        advance;
      logic        done;
      logic [3:0]  cmd;
      logic [16:0] va;
   } dpm_seq_s;

   // Transfer state.
   typedef enum logic {
      DPM_IDLE,
      DPM_ACTIVE
   } dpm_state_e;

endpackage

// File: dv/dpm_seq_model.sv
`timescale 1ns/1ns
`default_nettype none
// Stand-in for the data-transfer sequencer that drives the map's lookups.
module dpm_seq_model (
   input  wire logic             sys_clk,
   output var dpm_pkg::dpm_seq_s seq
);
   initial seq = '0;

   // One request pulse; the idle fields then flip so a stale value is never trusted.
   task automatic pulse(input logic [2:0] kind, input logic [3:0] cmd, input logic [16:0] va);
      @(posedge sys_clk);
      seq <= {kind, cmd, va};
      @(posedge sys_clk);
      seq <= {3'h0, ~cmd, ~va};
   endtask
endmodule
`default_nettype wire

// File: dv/test_dma_page_map_translation.sv
`timescale 1ns/1ns
`default_nettype none
module test_dma_page_map_translation;
   logic              sys_clk = 1'b0;
   logic              rst = 1'b1;
   logic [11:0]       reg_addr = 12'h000;
   logic              reg_wr = 1'b0;
   logic              reg_rd = 1'b0;
   logic [31:0]       reg_wdata = 32'h00000000;
   logic [31:0]       reg_rdata;
   logic              reg_rvalid;
   dpm_pkg::dpm_seq_s seq;
   logic              ie = 1'b0;
   logic              pe_clr = 1'b0;
   logic              inv_clr = 1'b0;
   logic              active;
   logic              page_err;
   logic              map_inv;
   logic              abort_p;
   logic              irq;
   logic [31:0]       phys;
   logic [31:0]       got;
   int                errors = 0;
   int                checked = 0;

   // Free-running 100 MHz clock.
   always #5 sys_clk = ~sys_clk;

   dpm_seq_model seq_model (.sys_clk(sys_clk), .seq(seq));

   dpm_page_map DUT (
      .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .seq(seq),
      .interrupt_enable_control(ie), .page_error_clr(pe_clr), .invalid_err_clr(inv_clr),
      .transfer_active_flag(active), .page_error_flag(page_err), .map_invalid_flag(map_inv),
      .xfer_abort(abort_p), .cpu_irq(irq), .phys_cmd_addr(phys)
   );

   // Compares one value and counts the outcome.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // Register write: strobe held for exactly one sampling edge.
   task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask

   // Register read: the answer must stand one cycle after the strobe edge.
   task automatic reg_read(input logic [11:0] a);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1;
      check({31'h0, reg_rvalid}, 32'h1, "read answer");
      got = reg_rdata;
   endtask

   // Write, then read the same word on the very next edge.
   task automatic reg_write_read(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b1;
      @(posedge sys_clk);
      reg_rd    <= 1'b0;
      #1;
      check({31'h0, reg_rvalid}, 32'h1, "back-to-back answer");
      got = reg_rdata;
   endtask

   // The last entry of a fresh map is invalid, and the view cannot be written.
   task automatic after_reset();
      reg_read(12'hBFC);
      check(got, 32'h0, "last entry after reset");
      reg_write(12'h010, 32'hFFFFFFFF);
      reg_read(12'h010);
      check(got, 32'h0, "view write ignored");
   endtask

   // Both ends of the map and the zero field, written then read back.
   task automatic map_fill();
      logic [11:0] at [3] = '{12'h800, 12'h804, 12'hBFC};
      logic [31:0] wv [3] = '{32'h00012345, 32'h80000055, 32'hFFFFFFFF};
      logic [31:0] rv [3] = '{32'h00012345, 32'h80000055, 32'h801FFFFF};
      for (int i = 0; i < 3; i++) begin
         reg_write(at[i], wv[i]);
      end
      for (int i = 0; i < 3; i++) begin
         reg_read(at[i]);
         check(got, rv[i], "map entry");
      end
      reg_write_read(12'h80C, 32'h40000033);
      check(got, 32'h00000033, "write then read");
   endtask

   // Transfer through entry 1 with a map write arriving while busy.
   task automatic busy_transfer();
      seq_model.pulse(3'h4, 4'h3, 17'h00200);
      #1;
      check({31'h0, active}, 32'h1, "busy after start");
      reg_read(12'h010);
      check(got, 32'h80000055, "selected view");
      reg_write(12'h014, 32'h0);
      reg_read(12'h014);
      check(got, 32'h30002A80, "capture word");
      reg_write(12'h804, 32'h80000077);
      reg_read(12'h804);
      check(got, 32'h80000055, "busy write dropped");
      check({31'h0, page_err}, 32'h1, "page error set");
      for (int i = 0; i < 4; i++) begin
         seq_model.pulse(3'h2, 4'h0, 17'h00000);
      end
      repeat (2) @(posedge sys_clk);
      #1;
      check(phys, 32'h30002A84, "capture follows address");
      seq_model.pulse(3'h1, 4'h0, 17'h00000);
      #1;
      check({30'h0, active, irq}, 32'h1, "end irq");
      @(posedge sys_clk);
      #1;
      check({31'h0, irq}, 32'h0, "irq one pulse");
   endtask

   // Transfer through the never-written entry 2 must be stopped.
   task automatic invalid_entry();
      int n;
      n = 0;
      seq_model.pulse(3'h4, 4'h5, 17'h00400);
      #1;
      while (abort_p !== 1'b1 && n < 6) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      check({30'h0, abort_p, map_inv}, 32'h3, "abort and flag");
      @(posedge sys_clk);
      #1;
      check({30'h0, active, irq}, 32'h0, "stopped, no irq");
      @(posedge sys_clk);
      pe_clr  <= 1'b1;
      inv_clr <= 1'b1;
      @(posedge sys_clk);
      pe_clr  <= 1'b0;
      inv_clr <= 1'b0;
      #1;
      check({30'h0, page_err, map_inv}, 32'h0, "flags cleared");
   endtask

   // Interrupt masked: a rejected write still flags, a second start is ignored.
   task automatic irq_masked();
      @(posedge sys_clk);
      ie <= 1'b0;
      seq_model.pulse(3'h4, 4'h3, 17'h00200);
      seq_model.pulse(3'h4, 4'h9, 17'h00400);
      reg_write(12'h804, 32'h00000011);
      reg_read(12'h010);
      check(got, 32'h80000055, "restart ignored");
      check({30'h0, active, page_err}, 32'h3, "masked reject");
      seq_model.pulse(3'h1, 4'h0, 17'h00000);
      #1;
      check({30'h0, active, irq}, 32'h0, "masked end");
   endtask

   // Prints the counts and the verdict, then stops the run.
   task automatic complete_run();
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Main sequence; the host only touches the map while idle except on purpose.
   initial begin
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      ie  <= 1'b1;
      after_reset();
      map_fill();
      busy_transfer();
      invalid_entry();
      irq_masked();
      complete_run();
   end

   // Watchdog far beyond the fewer than one hundred cycles the tests need.
   initial begin
      #20000;
      errors++;
      complete_run();
   end
endmodule
`default_nettype wire
